// File: slp_latch_power.sv
// Purpose: Programming latches and power-down control of the synthesizer.
// Assumes: Serial clock stands still while the strobe is high.
// Notes:   Strobe, chip enable, reference output and lock pass two flops.
module slp_latch_power (
	input  wire logic        clk_sys,                // System clock, 20 MHz
	input  wire logic        sys_rst,                // Synchronous reset, active high
	input  wire logic        link_sclk,              // Serial clock of the link
	input  wire logic        link_sdata,             // Serial data
	input  wire logic        latch_strobe,           // Latch strobe, rising edge transfers
	input  wire logic        chip_enable,            // Hardware enable, low disables
	input  wire logic        ref_div_out,            // Reference divider output
	input  wire logic        lock_detected,          // Digital lock detect level
	output logic             device_powered,         // Device active
	output logic             bias_enable,            // DC current paths on
	output logic             ref_buffer_enable,      // Reference input buffer on
	output logic             pump_tristate,          // Charge pump in three-state
	output logic             rf_out_enable,          // RF output stage biased
	output logic             counters_load,          // Hold counters in load state
	output logic             lock_detect_reset,      // Hold lock detector in reset
	output logic [1:0]       prescaler_sel,          // Prescaler modulus code
	output logic [2:0]       pump_current1,          // Current setting 1
	output logic [2:0]       pump_current2,          // Current setting 2
	output logic [2:0]       pump_current_act,       // Setting in use
	output logic             pump_gain_select,       // Latest gain bit
	output logic [1:0]       out_power_level,        // Output power code
	output logic             mute_until_locked,      // Mute-until-lock enable
	output logic             detector_polarity,      // Phase detector polarity
	output logic [2:0]       mux_select,             // Output multiplexer select
	output logic             counter_clear,          // Counter reset bit
	output logic [1:0]       core_power,             // Core power code
	output logic [12:0]      feedback_b,             // B counter value
	output logic [4:0]       feedback_a,             // A counter value
	output logic             halved_feedback_select, // Halved output to prescaler
	output logic             output_halving,         // Output divide by two
	output logic [13:0]      ref_count,              // Reference divide ratio
	output logic [1:0]       antibacklash_width,     // Antibacklash pulse code
	output logic             lock_precision,         // Lock detect precision
	output logic [1:0]       band_clock_div,         // Band select clock divider
	output logic             factory_test_bit        // Test mode bit
);
	import slp_pkg::*;

	typedef struct packed {
		logic [SLP_WORD_W-1:0] ctrl;
		logic [SLP_WORD_W-1:0] fbk;
		logic [SLP_WORD_W-1:0] refl;
		logic                  gain;
		slp_pwr_t              st;
		logic [1:0]            edges;
		logic                  le_s1;
		logic                  le_s2;
		logic                  le_s3;
		logic                  ref_s1;
		logic                  ref_s2;
		logic                  ref_s3;
		logic                  ce_s1;
		logic                  ce_s2;
		logic                  lock_s1;
		logic                  lock_s2;
	} slp_state_t;

	slp_state_t             q;
	slp_state_t             d;
	logic [SLP_WORD_W-1:0]  word;
	logic [1:0]             sel;
	logic                   le_rise;
	logic                   ref_rise;
	logic                   wr_ctrl;
	logic                   wr_fbk;
	logic                   wr_ref;
	logic                   up;

	slp_shift u_shift (
		.link_sclk  (link_sclk),
		.link_sdata (link_sdata),
		.shift_q    (word)
	);

	// The word is static by the time the synchronised strobe edge is seen,
	// since the link clock has stopped; so a parallel grab is safe here.
	assign sel      = 2'(slp_fld(word, SLP_SEL_LSB));
	assign le_rise  = q.le_s2 & ~q.le_s3;
	assign ref_rise = q.ref_s2 & ~q.ref_s3;
	assign wr_ctrl  = le_rise && (sel == SLP_SEL_CTRL);
	assign wr_fbk   = le_rise && (sel == SLP_SEL_FBK);
	assign wr_ref   = le_rise && (sel == SLP_SEL_REF);

	always_comb begin
		d = q;
		d.le_s1   = latch_strobe;
		d.le_s2   = q.le_s1;
		d.le_s3   = q.le_s2;
		d.ref_s1  = ref_div_out;
		d.ref_s2  = q.ref_s1;
		d.ref_s3  = q.ref_s2;
		d.ce_s1   = chip_enable;
		d.ce_s2   = q.ce_s1;
		d.lock_s1 = lock_detected;
		d.lock_s2 = q.lock_s1;
		// Latches change only on writes, never on power-down
		if (wr_ctrl) begin
			d.ctrl = word;
			d.gain = word[SLP_C_GAIN];
		end
		if (wr_fbk) begin
			d.fbk  = word;
			d.gain = word[SLP_F_GAIN];
		end
		if (wr_ref) begin
			d.refl = word;
		end
		// Test latch code is accepted on the link and dropped
		if (wr_ctrl) begin
			if (!word[SLP_C_PD_REQ]) begin
				d.st = SLP_ON;
			end else if (word[SLP_C_PD_SYNC]) begin
				d.st    = SLP_ARMED;
				d.edges = 2'h0;
			end else begin
				d.st = SLP_DOWN;
			end
		end else begin
			unique case (q.st)
				SLP_OFF, SLP_ON, SLP_DOWN: begin
				end
				SLP_ARMED: begin
					if (ref_rise) begin
						d.edges = q.edges + 2'h1;
						if (q.edges + 2'h1 == SLP_SYNC_EDGES) begin
							d.st = SLP_DOWN;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			q       <= '0;
			q.ctrl  <= SLP_LATCH_RST;
			q.fbk   <= SLP_LATCH_RST;
			q.refl  <= SLP_LATCH_RST;
			q.st    <= SLP_OFF;
		end else begin
			q <= d;
		end
	end

	// Still up while armed: the gated request waits for the reference edges.
	// Chip enable carries two cycles of synchroniser latency.
	assign up = ((q.st == SLP_ON) || (q.st == SLP_ARMED)) && q.ce_s2;

	assign device_powered    = up;
	assign bias_enable       = up;
	assign ref_buffer_enable = up;
	assign pump_tristate     = !up || q.ctrl[SLP_C_TRI];
	assign rf_out_enable     = up && (!q.ctrl[SLP_C_MUTE] || q.lock_s2);
	assign counters_load     = !up;
	assign lock_detect_reset = !up;

	assign prescaler_sel     = 2'(slp_fld(q.ctrl, SLP_C_PRESC));
	assign pump_current1     = 3'(slp_fld(q.ctrl, SLP_C_CUR1));
	assign pump_current2     = 3'(slp_fld(q.ctrl, SLP_C_CUR2));
	assign pump_gain_select  = q.gain;
	assign pump_current_act  = q.gain ? pump_current2 : pump_current1;
	assign out_power_level   = 2'(slp_fld(q.ctrl, SLP_C_OUTPWR));
	assign mute_until_locked = q.ctrl[SLP_C_MUTE];
	assign detector_polarity = q.ctrl[SLP_C_POL];
	assign mux_select        = 3'(slp_fld(q.ctrl, SLP_C_MUX));
	assign counter_clear     = q.ctrl[SLP_C_CLR];
	assign core_power        = 2'(slp_fld(q.ctrl, SLP_C_CORE));

	assign feedback_b             = 13'(slp_fld(q.fbk, SLP_F_B));
	assign feedback_a             = 5'(slp_fld(q.fbk, SLP_F_A));
	assign halved_feedback_select = q.fbk[SLP_F_HALVSEL];
	assign output_halving         = q.fbk[SLP_F_HALV];

	assign ref_count          = 14'(slp_fld(q.refl, SLP_R_CNT));
	assign antibacklash_width = 2'(slp_fld(q.refl, SLP_R_ABP));
	assign lock_precision     = q.refl[SLP_R_LDP];
	assign band_clock_div     = 2'(slp_fld(q.refl, SLP_R_BCLK));
	assign factory_test_bit   = q.refl[SLP_R_TEST];

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);

	chk_ctrl_load: assert property (wr_ctrl |=> q.ctrl == $past(word))
		else $error("control latch not loaded");
	chk_fbk_load: assert property (wr_fbk |=> q.fbk == $past(word) && $stable(q.ctrl))
		else $error("feedback latch not loaded");
	chk_ref_load: assert property (wr_ref |=> q.refl == $past(word) && $stable(q.fbk))
		else $error("reference latch not loaded");
	chk_async_down: assert property (wr_ctrl && word[SLP_C_PD_REQ] && !word[SLP_C_PD_SYNC]
		|=> !device_powered && q.st == SLP_DOWN)
		else $error("immediate power-down missed");
	chk_sync_first: assert property (q.st == SLP_ARMED && q.edges == 2'h0 && ref_rise && !wr_ctrl
		|=> q.st == SLP_ARMED ##0 q.edges == 2'h1)
		else $error("gated power-down too early");
	chk_sync_second: assert property (q.st == SLP_ARMED && q.edges == 2'h1 && ref_rise && !wr_ctrl
		|=> q.st == SLP_DOWN ##0 !device_powered)
		else $error("gated power-down not on second edge");
	chk_ce_disable: assert property (!chip_enable
		|-> ##2 (!device_powered && pump_tristate && !rf_out_enable))
		else $error("chip enable low did not disable");
	chk_down_effects: assert property (!device_powered
		|-> counters_load && lock_detect_reset && !ref_buffer_enable && !bias_enable)
		else $error("power-down side effects missing");
	chk_power_up: assert property (wr_ctrl && !word[SLP_C_PD_REQ]
		|=> q.st == SLP_ON && (device_powered || !q.ce_s2))
		else $error("control write did not power up");
	chk_gain_latest: assert property ((wr_ctrl && !wr_fbk) ##1 !le_rise [*2]
		|-> pump_gain_select == $past(word[SLP_C_GAIN], 2))
		else $error("gain bit not latest value");
	chk_mute_lock: assert property (q.ctrl[SLP_C_MUTE] && !q.lock_s2 |-> !rf_out_enable)
		else $error("outputs on before lock");
	chk_latch_keep: assert property (!device_powered && !le_rise |=> $stable(q.ctrl) && $stable(q.fbk))
		else $error("latch lost during power-down");

	// Field checks use part-selects of the word, not the output decode
	chk_presc_field: assert property (
		wr_ctrl
		|=> prescaler_sel == $past(word[SLP_C_PRESC +: 2]))
		else $error("prescaler field not loaded");

	chk_cur_fields: assert property (
		wr_ctrl
		|=> pump_current1 == $past(word[SLP_C_CUR1 +: 3]) && pump_current2 == $past(word[SLP_C_CUR2 +: 3]))
		else $error("pump current fields not loaded");

	chk_out_power: assert property (
		wr_ctrl
		|=> out_power_level == $past(word[SLP_C_OUTPWR +: 2]))
		else $error("output power field not loaded");

	chk_mute_field: assert property (
		wr_ctrl
		|=> mute_until_locked == $past(word[SLP_C_MUTE]))
		else $error("mute bit not loaded");

	chk_gain_two: assert property (
		pump_gain_select
		|-> pump_current_act == pump_current2)
		else $error("gain set but setting 1 in use");

	chk_gain_one: assert property (
		!pump_gain_select
		|-> pump_current_act == pump_current1)
		else $error("gain clear but setting 2 in use");

	chk_fbk_gain: assert property (
		wr_fbk
		|=> pump_gain_select == $past(word[SLP_F_GAIN]))
		else $error("feedback write did not set gain");

	chk_ctrl_gain: assert property (
		wr_ctrl
		|=> pump_gain_select == $past(word[SLP_C_GAIN]))
		else $error("control write did not set gain");

	chk_mux_core: assert property (
		wr_ctrl
		|=> mux_select == $past(word[SLP_C_MUX +: 3]) && core_power == $past(word[SLP_C_CORE +: 2]))
		else $error("mux or core field not loaded");

	chk_pol_clear: assert property (
		wr_ctrl
		|=> detector_polarity == $past(word[SLP_C_POL]) && counter_clear == $past(word[SLP_C_CLR]))
		else $error("polarity or clear bit not loaded");

	chk_tri_bit: assert property (
		q.ctrl[SLP_C_TRI]
		|-> pump_tristate)
		else $error("three-state bit ignored");

	chk_test_drop: assert property (
		le_rise && (&sel)
		|=> $stable(q.ctrl) && $stable(q.fbk) && $stable(q.refl))
		else $error("test latch code changed a latch");

	chk_ctrl_only: assert property (
		wr_ctrl
		|=> $stable(q.fbk) && $stable(q.refl))
		else $error("control write touched another latch");

	chk_down_pump: assert property (
		!device_powered
		|-> pump_tristate && !rf_out_enable)
		else $error("pump or outputs active while down");

	chk_down_write: assert property (
		!device_powered && wr_ref
		|=> q.refl == $past(word))
		else $error("write refused while powered down");

	chk_armed_up: assert property (
		q.st == SLP_ARMED && q.ce_s2
		|-> device_powered)
		else $error("gated request powered down early");

	chk_sync_arm: assert property (
		wr_ctrl && word[SLP_C_PD_REQ] && word[SLP_C_PD_SYNC]
		|=> q.st == SLP_ARMED && q.edges == 2'h0)
		else $error("gated request not armed");

	chk_armed_hold: assert property (
		q.st == SLP_ARMED && !ref_rise && !wr_ctrl
		|=> q.st == SLP_ARMED && $stable(q.edges))
		else $error("armed state moved without edge");

	chk_down_hold: assert property (
		q.st == SLP_DOWN && !wr_ctrl
		|=> q.st == SLP_DOWN)
		else $error("left power-down without a write");

	chk_ce_resume: assert property (
		q.st == SLP_ON && $rose(q.ce_s2)
		|-> device_powered)
		else $error("no resume after chip enable");

	chk_fbk_fields: assert property (
		wr_fbk
		|=> feedback_b == $past(word[SLP_F_B +: 13]) && feedback_a == $past(word[SLP_F_A +: 5]))
		else $error("feedback counter fields not loaded");

	chk_halving_bits: assert property (
		wr_fbk
		|=> halved_feedback_select == $past(word[SLP_F_HALVSEL]) && output_halving == $past(word[SLP_F_HALV]))
		else $error("halving bits not loaded");

	chk_ref_fields: assert property (
		wr_ref
		|=> ref_count == $past(word[SLP_R_CNT +: 14]) && antibacklash_width == $past(word[SLP_R_ABP +: 2]))
		else $error("reference count fields not loaded");

	chk_ref_bits: assert property (
		wr_ref
		|=> lock_precision == $past(word[SLP_R_LDP]) && band_clock_div == $past(word[SLP_R_BCLK +: 2])
			&& factory_test_bit == $past(word[SLP_R_TEST]))
		else $error("reference control bits not loaded");

	chk_lock_unmute: assert property (
		device_powered && q.lock_s2
		|-> rf_out_enable)
		else $error("outputs off after lock");

	chk_no_mute: assert property (
		device_powered && !mute_until_locked
		|-> rf_out_enable)
		else $error("outputs muted without mute bit");

	cov_sync_down: cover property (q.st == SLP_ARMED ##[1:1000] q.st == SLP_DOWN);
	cov_async_down: cover property (wr_ctrl && word[SLP_C_PD_REQ] && !word[SLP_C_PD_SYNC]);
	cov_first_up: cover property (q.st == SLP_OFF ##1 q.st == SLP_ON);
	cov_write_while_down: cover property (q.st == SLP_DOWN && wr_fbk);
	cov_ce_off: cover property (q.st == SLP_ON && !q.ce_s2);
endmodule

// File: slp_pkg.sv
// Purpose: Shared constants for the synthesizer latch and power-down block.
// Assumes: 24-bit words, select bits in the two lowest positions.
// Notes:   Field positions are bit indices inside a latched word.
// Contract
// - 24 bits MSB first, latch on strobe
// - Select 00 loads control latch
// - Select 10 feedback, 01 reference latch
// - Control write powers up device initially
// - Bits 21 and 20 select power-down mode
// - Sync bit zero: request powers down immediately
// - Both set: down on second reference edge
// - Chip enable low disables device at once; code takes two clock cycles
// - Power-down loads counters, resets lock detect
// - Power-down tristates pump, outputs, reference buffer
// - Serial input stays active while powered down
// - Prescaler modulus from bits 23 and 22
// - Pump current settings from low/high bits
// - Output power from bits 13 and 12
// - Mute outputs until lock when bit set
// - Gain bit picks current setting 2
// - Gain bit follows most recent write
package slp_pkg;
	localparam int SLP_WORD_W = 24;
	localparam logic [1:0] SLP_SEL_CTRL = 2'h0;
	localparam logic [1:0] SLP_SEL_FBK  = 2'h2;
	localparam logic [1:0] SLP_SEL_REF  = 2'h1;
	localparam int SLP_SEL_LSB = 0;
	// Control latch
	localparam int SLP_C_PRESC   = 22;
	localparam int SLP_C_PD_SYNC = 21;
	localparam int SLP_C_PD_REQ  = 20;
	localparam int SLP_C_CUR2    = 17;
	localparam int SLP_C_CUR1    = 14;
	localparam int SLP_C_OUTPWR  = 12;
	localparam int SLP_C_MUTE    = 11;
	localparam int SLP_C_GAIN    = 10;
	localparam int SLP_C_TRI     = 9;
	localparam int SLP_C_POL     = 8;
	localparam int SLP_C_MUX     = 5;
	localparam int SLP_C_CLR     = 4;
	localparam int SLP_C_CORE    = 2;
	// Feedback divider latch
	localparam int SLP_F_HALVSEL = 23;
	localparam int SLP_F_HALV    = 22;
	localparam int SLP_F_GAIN    = 21;
	localparam int SLP_F_B       = 8;
	localparam int SLP_F_A       = 2;
	// Reference divider latch
	localparam int SLP_R_BCLK    = 20;
	localparam int SLP_R_TEST    = 19;
	localparam int SLP_R_LDP     = 18;
	localparam int SLP_R_ABP     = 16;
	localparam int SLP_R_CNT     = 2;
	// Reference edges counted before a gated power-down
	localparam logic [1:0] SLP_SYNC_EDGES = 2'h2;
	localparam logic [SLP_WORD_W-1:0] SLP_LATCH_RST = 24'h000000;

	typedef enum logic [1:0] {SLP_OFF, SLP_ON, SLP_ARMED, SLP_DOWN} slp_pwr_t;

	function automatic logic [SLP_WORD_W-1:0] slp_fld(input logic [SLP_WORD_W-1:0] w, input int lsb);
		slp_fld = w >> lsb;
	endfunction
endpackage

// File: slp_shift.sv
// Purpose: Serial input shift register on the link clock.
// Assumes: Link clock only toggles while a word is being shifted.
// Notes:   No reset; the word is only used once a strobe is seen.
module slp_shift (
	input  wire logic                         link_sclk,  // Serial clock from controller
	input  wire logic                         link_sdata, // Serial data, MSB first
	output logic [slp_pkg::SLP_WORD_W-1:0]    shift_q     // Last 24 bits shifted in
);
	import slp_pkg::*;

	logic [SLP_WORD_W-1:0] shift_d;

	// Never gated by power state, so writes still land while powered down
	always_comb begin
		shift_d = {shift_q[SLP_WORD_W-2:0], link_sdata};
	end

	always_ff @(posedge link_sclk) begin
		shift_q <= shift_d;
	end
endmodule

// File: slp_host_model.sv
// Purpose: Behavioural controller that drives the three-wire programming link.
// Assumes: Serial clock period 30 ns, started off-phase from the system clock.
// Notes:   Serial clock stands still outside frames; data inverts once released.
module slp_host_model (
	output logic link_sclk,    // Serial clock, runs only inside a frame
	output logic link_sdata,   // Serial data, MSB first
	output logic latch_strobe  // Rising edge moves the word into a latch
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		link_sclk = 1'b0;
		link_sdata = 1'b0;
		latch_strobe = 1'b0;
	end

	// Strobe is held long enough for the two-flop synchroniser on the far side
	task automatic send(input logic [23:0] w);
		#7;
		for (int i = 23; i >= 0; i--) begin
			link_sdata = w[i];
			#15;
			link_sclk = 1'b1;
			#15;
			link_sclk = 1'b0;
		end
		// Released line must not keep showing the last bit
		link_sdata = ~w[0];
		#40;
		latch_strobe = 1'b1;
		#400;
		latch_strobe = 1'b0;
		#300;
	endtask
endmodule

// File: test_slp_latch_power.sv
// Purpose: Self-checking bench for the latch and power-down block.
// Assumes: Words reach the block through the controller model only.
// Notes:   Expected values are worked out by hand from the field layout.
module test_slp_latch_power;
	timeunit 1ns;
	timeprecision 1ps;
	import slp_pkg::*;

	logic        clk_sys, sys_rst, chip_enable, ref_div_out, lock_detected;
	logic        link_sclk, link_sdata, latch_strobe;
	logic        device_powered, bias_enable, ref_buffer_enable, pump_tristate, rf_out_enable;
	logic        counters_load, lock_detect_reset, pump_gain_select, mute_until_locked;
	logic        detector_polarity, counter_clear, halved_feedback_select, output_halving;
	logic        lock_precision, factory_test_bit;
	logic [1:0]  prescaler_sel, out_power_level, core_power, antibacklash_width, band_clock_div;
	logic [2:0]  pump_current1, pump_current2, pump_current_act, mux_select;
	logic [12:0] feedback_b;
	logic [4:0]  feedback_a;
	logic [13:0] ref_count;
	int          failures = 0;
	int          compares = 0;

	slp_latch_power dut (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .link_sclk(link_sclk), .link_sdata(link_sdata),
		.latch_strobe(latch_strobe), .chip_enable(chip_enable), .ref_div_out(ref_div_out),
		.lock_detected(lock_detected), .device_powered(device_powered), .bias_enable(bias_enable),
		.ref_buffer_enable(ref_buffer_enable), .pump_tristate(pump_tristate), .rf_out_enable(rf_out_enable),
		.counters_load(counters_load), .lock_detect_reset(lock_detect_reset), .prescaler_sel(prescaler_sel),
		.pump_current1(pump_current1), .pump_current2(pump_current2), .pump_current_act(pump_current_act),
		.pump_gain_select(pump_gain_select), .out_power_level(out_power_level),
		.mute_until_locked(mute_until_locked), .detector_polarity(detector_polarity), .mux_select(mux_select),
		.counter_clear(counter_clear), .core_power(core_power), .feedback_b(feedback_b),
		.feedback_a(feedback_a), .halved_feedback_select(halved_feedback_select),
		.output_halving(output_halving), .ref_count(ref_count),
		.antibacklash_width(antibacklash_width), .lock_precision(lock_precision),
		.band_clock_div(band_clock_div), .factory_test_bit(factory_test_bit)
	);
	slp_host_model host (.link_sclk(link_sclk), .link_sdata(link_sdata), .latch_strobe(latch_strobe));

	always #25 clk_sys = ~clk_sys;

	function automatic logic [6:0] pwr();
		return {device_powered, bias_enable, ref_buffer_enable, rf_out_enable,
			pump_tristate, counters_load, lock_detect_reset};
	endfunction

	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %0t ns: saw %h, wanted %h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	task automatic ref_pulse();
		@(posedge clk_sys) ref_div_out <= 1'b1;
		repeat (4) @(posedge clk_sys);
		ref_div_out <= 1'b0;
		cyc(4);
	endtask

	task automatic wrap_up();
		if (failures == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// A hang past about three times the expected run length counts as a failure
	initial begin
		#2ms;
		failures++;
		wrap_up();
	end

	initial begin
		clk_sys = 1'b0;
		sys_rst = 1'b1;
		chip_enable = 1'b1;
		ref_div_out = 1'b0;
		lock_detected = 1'b0;
		repeat (4) @(posedge clk_sys);
		sys_rst <= 1'b0;
		cyc(2);
		chk(pwr(), 7'h07);
		host.send(24'h162AF1);
		chk({band_clock_div, factory_test_bit, lock_precision, antibacklash_width, ref_count},
			{2'h1, 1'b0, 1'b1, 2'h2, 14'h0ABC});
		chk(pwr(), 7'h07);
		host.send(24'h8AF1D8);
		chk(pwr(), 7'h78);
		chk({prescaler_sel, pump_current2, pump_current1, out_power_level, mute_until_locked,
			pump_gain_select, detector_polarity, mux_select, counter_clear, core_power},
			{2'h2, 3'h5, 3'h3, 2'h3, 1'b0, 1'b0, 1'b1, 3'h6, 1'b1, 2'h2});
		chk(pump_current_act, 3'h3);
		#600us;
		host.send(24'hA12346);
		chk({halved_feedback_select, output_halving, feedback_b, feedback_a},
			{1'b1, 1'b0, 13'h0123, 5'h11});
		chk({pump_gain_select, pump_current_act}, {1'b1, 3'h5});
		host.send(24'hFFFFFF);
		chk({feedback_b, ref_count}, {13'h0123, 14'h0ABC});
		host.send(24'h8AF9D8);
		chk({pump_gain_select, pump_current_act, mute_until_locked, rf_out_enable},
			{1'b0, 3'h3, 1'b1, 1'b0});
		@(posedge clk_sys) lock_detected <= 1'b1;
		cyc(5);
		chk(rf_out_enable, 1'b1);
		host.send(24'h9AF1D8);
		chk(pwr(), 7'h07);
		// Only the reference latch is touched while down; feedback stays put
		host.send(24'h1E0005);
		chk(ref_count, 14'h0001);
		chk(factory_test_bit, 1'b1);
		chk({feedback_b, feedback_a}, {13'h0123, 5'h11});
		host.send(24'h8AF1D8);
		chk(pwr(), 7'h78);
		host.send(24'hBAF1D8);
		chk(device_powered, 1'b1);
		ref_pulse();
		chk(device_powered, 1'b1);
		ref_pulse();
		chk(pwr(), 7'h07);
		host.send(24'h8AF1D8);
		@(posedge clk_sys) chip_enable <= 1'b0;
		cyc(4);
		chk(pwr(), 7'h07);
		@(posedge clk_sys) chip_enable <= 1'b1;
		cyc(4);
		chk(pwr(), 7'h78);
		host.send(24'h60030E);
		chk({halved_feedback_select, output_halving, pump_gain_select, feedback_b, feedback_a},
			{1'b0, 1'b1, 1'b1, 13'h0003, 5'h03});
		wrap_up();
	end
endmodule
